// *** shared/dcr_pkg.sv ***
// Shared constants of the driver configuration register bank
package dcr_pkg;

  // Bus geometry: byte address, 32-bit data, one word per register index
  localparam int ADDR_W = 10;
  localparam int DATA_W = 32;
  localparam int BE_W = 4;

  // Register indices; byte address is four times the index
  localparam logic [7:0] ALGO_ONE_IDX = 8'ha0;
  localparam logic [7:0] ALGO_TWO_IDX = 8'ha2;
  localparam logic [7:0] GD_TWO_IDX = 8'hae;

  // Reset values
  localparam logic [31:0] ALGO_RESET = 32'h00000000;
  localparam logic [31:0] GD_TWO_RESET = 32'h01200000;

  // Field positions of gate_driver_config_two
  localparam int PARITY_BIT = 31;
  localparam int DELAY_COMP_BIT = 30;
  localparam int TD_MSB = 29;
  localparam int TD_LSB = 26;
  localparam int SEQ_OFF_BIT = 24;
  localparam int CUR_LIM_BIT = 23;
  localparam int VSEL_MSB = 22;
  localparam int VSEL_LSB = 21;

  // Regulator voltage codes
  localparam logic [1:0] VSEL_3V3 = 2'h0;
  localparam logic [1:0] VSEL_5V0 = 2'h1;
  localparam logic [1:0] VSEL_4V0 = 2'h2;
  localparam logic [1:0] VSEL_5V7 = 2'h3;

  // Current limit codes
  localparam logic CUR_LIM_600MA = 1'b0;
  localparam logic CUR_LIM_150MA = 1'b1;

  // Target delay timing: code n (1..15) means (n + 1) steps of 0.2 us
  localparam int CLK_PERIOD_NS = 8;
  localparam int TD_STEP_NS = 200;
  localparam int TD_STEP_CYC = (TD_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TD_CYC_W = 10;

  // Avalon response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECODE_ERR = 2'h3;

endpackage

// *** core/dcr_bus_handshake.sv ***
`timescale 1ns/1ps
// Waitrequest sequencer: every request waits exactly one cycle, then is answered
module dcr_bus_handshake (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Request strobes from the master
  input wire logic read,
  input wire logic write,
  // Answer
  output logic waitrequest,
  output logic capture
);

  logic wait_q;

  // A new request is first seen while waitrequest is still high
  assign capture = (read | write) & wait_q;
  assign waitrequest = wait_q;

  // Drop waitrequest for a single cycle; master releases at that edge
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      wait_q <= 1'b1;
    end else if (!wait_q) begin
      wait_q <= 1'b1;
    end else if (read | write) begin
      wait_q <= 1'b0;
    end
  end

endmodule // dcr_bus_handshake

// *** core/dcr_delay_decode.sv ***
`timescale 1ns/1ps
// Turns the target delay code into an auto flag and a delay in clock cycles
module dcr_delay_decode (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Code from the configuration word
  input wire logic [3:0] code,
  // Decoded target
  output logic auto_mode,
  output logic [dcr_pkg::TD_CYC_W-1:0] delay_cycles
);

  import dcr_pkg::*;

  logic auto_q;
  logic [TD_CYC_W-1:0] cyc_q;

  assign auto_mode = auto_q;
  assign delay_cycles = cyc_q;

  // Code zero hands the delay to the slew-rate logic, others are 0.4..3.2 us
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      auto_q <= 1'b1;
      cyc_q <= '0;
    end else if (code == 4'h0) begin
      auto_q <= 1'b1;
      cyc_q <= '0;
    end else begin
      auto_q <= 1'b0;
      cyc_q <= TD_CYC_W'((TD_CYC_W'(code) + TD_CYC_W'(1)) * TD_STEP_CYC);
    end
  end

endmodule // dcr_delay_decode

// *** core/dcr_top.sv ***
`timescale 1ns/1ps
// Overview of operation
// - Bit 30 of the gate driver word enables driver delay compensation, reset zero.
// - Bits 29-26 pick auto delay at code zero, else 0.4 us to 3.2 us in 0.2 us steps.
// - Bit 24 resets to one (sequencing off) and is cleared only by writing a one.
// - Bit 23 selects the regulator current limit, zero 600 mA and one 150 mA, reset zero.
// - Bits 22-21 select 3.3, 5.0, 4.0 or 5.7 V as codes 0 to 3, reset code 1.
// - The algorithm words sit at A0h and A2h and reset to all zeros.
// - The gate driver word sits at AEh and resets to 01200000h as a whole.
module dcr_top (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Avalon-MM slave
  input wire logic [dcr_pkg::ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [dcr_pkg::DATA_W-1:0] writedata,
  input wire logic [dcr_pkg::BE_W-1:0] byteenable,
  output logic [dcr_pkg::DATA_W-1:0] readdata,
  output logic [1:0] response,
  output logic waitrequest,
  // Gate driver controls
  output logic delay_comp_en,
  output logic target_delay_auto,
  output logic [dcr_pkg::TD_CYC_W-1:0] target_delay_cycles,
  // Regulator controls
  output logic regulator_sequencing_off,
  output logic regulator_current_limit_sel,
  output logic [1:0] regulator_voltage_sel,
  // Internal algorithm words
  output logic [dcr_pkg::DATA_W-1:0] algorithm_config_one,
  output logic [dcr_pkg::DATA_W-1:0] algorithm_config_two
);

  import dcr_pkg::*;

  // Register state
  logic [DATA_W-1:0] gd_two_q;
  logic [DATA_W-1:0] gd_two_d;
  logic [DATA_W-1:0] algo_one_q;
  logic [DATA_W-1:0] algo_two_q;
  logic [DATA_W-1:0] readdata_q;
  logic [1:0] response_q;

  // Bus decode
  logic capture;
  logic accept_wr;
  logic hit_gd;
  logic hit_one;
  logic hit_two;
  logic hit_any;

  // True when a byte address names the given register index exactly
  function automatic logic dcr_hit(input logic [ADDR_W-1:0] addr, input logic [7:0] idx);
    return (addr[1:0] == 2'h0) && (addr[ADDR_W-1:2] == idx);
  endfunction

  // Byte-lane merge of write data into the old word
  function automatic logic [DATA_W-1:0] dcr_merge(input logic [DATA_W-1:0] old,
                                                  input logic [DATA_W-1:0] wd,
                                                  input logic [BE_W-1:0] be);
    logic [DATA_W-1:0] res;
    res = old;
    for (int i = 0; i < BE_W; i++) begin
      if (be[i]) begin
        res[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return res;
  endfunction

  // Handshake: one wait cycle, answer on the next
  dcr_bus_handshake u_handshake (
    .core_clk(core_clk),
    .reset(reset),
    .read(read),
    .write(write),
    .waitrequest(waitrequest),
    .capture(capture)
  );

  // Address decode; misaligned or unlisted addresses hit nothing
  assign hit_gd = dcr_hit(address, GD_TWO_IDX);
  assign hit_one = dcr_hit(address, ALGO_ONE_IDX);
  assign hit_two = dcr_hit(address, ALGO_TWO_IDX);
  assign hit_any = hit_gd | hit_one | hit_two;

  // Writes take effect only at the edge where waitrequest is low
  assign accept_wr = write & ~waitrequest;

  // Next gate driver word: plain lanes, then bit 24 as write-one-to-clear
  always_comb begin
    gd_two_d = dcr_merge(gd_two_q, writedata, byteenable);
    if (byteenable[SEQ_OFF_BIT/8]) begin
      // A zero written here must not set the bit back
      gd_two_d[SEQ_OFF_BIT] = gd_two_q[SEQ_OFF_BIT] & ~writedata[SEQ_OFF_BIT];
    end else begin
      gd_two_d[SEQ_OFF_BIT] = gd_two_q[SEQ_OFF_BIT];
    end
  end

  // Gate driver configuration word
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      gd_two_q <= GD_TWO_RESET;
    end else if (accept_wr && hit_gd) begin
      gd_two_q <= gd_two_d;
    end
  end

  // First internal algorithm word
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      algo_one_q <= ALGO_RESET;
    end else if (accept_wr && hit_one) begin
      algo_one_q <= dcr_merge(algo_one_q, writedata, byteenable);
    end
  end

  // Second internal algorithm word
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      algo_two_q <= ALGO_RESET;
    end else if (accept_wr && hit_two) begin
      algo_two_q <= dcr_merge(algo_two_q, writedata, byteenable);
    end
  end

  // Read data is latched in the wait cycle so it stands during the answer
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      readdata_q <= '0;
      response_q <= RESP_OKAY;
    end else if (capture && read) begin
      if (hit_gd) begin
        readdata_q <= gd_two_q;
      end else if (hit_one) begin
        readdata_q <= algo_one_q;
      end else if (hit_two) begin
        readdata_q <= algo_two_q;
      end else begin
        readdata_q <= '0;
      end
      response_q <= hit_any ? RESP_OKAY : RESP_DECODE_ERR;
    end
  end

  // Target delay decode is registered, so it trails the field by one cycle
  dcr_delay_decode u_delay_decode (
    .core_clk(core_clk),
    .reset(reset),
    .code(gd_two_q[TD_MSB:TD_LSB]),
    .auto_mode(target_delay_auto),
    .delay_cycles(target_delay_cycles)
  );

  // Outputs come straight from the stored fields
  assign readdata = readdata_q;
  assign response = response_q;
  assign delay_comp_en = gd_two_q[DELAY_COMP_BIT];
  assign regulator_sequencing_off = gd_two_q[SEQ_OFF_BIT];
  assign regulator_current_limit_sel = gd_two_q[CUR_LIM_BIT];
  assign regulator_voltage_sel = gd_two_q[VSEL_MSB:VSEL_LSB];
  assign algorithm_config_one = algo_one_q;
  assign algorithm_config_two = algo_two_q;

  // Checks, all on the single clock domain
  default clocking dcr_cb @(posedge core_clk);
  endclocking
  default disable iff (reset);

  // A write to the gate driver word with the top lane enabled
  sequence seq_gd_top_write;
    accept_wr && hit_gd && byteenable[3];
  endsequence

  // A write to the gate driver word with the third lane enabled
  sequence seq_gd_mid_write;
    accept_wr && hit_gd && byteenable[2];
  endsequence

  // A request first seen, then answered on the next cycle
  sequence seq_request_seen;
    (read || write) && waitrequest;
  endsequence

  sequence seq_answer;
    !waitrequest;
  endsequence

  chk_delay_comp_write: assert property (
    seq_gd_top_write |=> delay_comp_en == $past(writedata[DELAY_COMP_BIT]))
    else $error("delay compensation enable did not follow the write");

  chk_delay_decode_map: assert property (
    ($past(gd_two_q[TD_MSB:TD_LSB]) != 4'h0) |->
      (!target_delay_auto && target_delay_cycles ==
        TD_CYC_W'((TD_CYC_W'($past(gd_two_q[TD_MSB:TD_LSB])) + TD_CYC_W'(1)) * TD_STEP_CYC)))
    else $error("target delay cycles do not match the code");

  chk_delay_auto_zero: assert property (
    ($past(gd_two_q[TD_MSB:TD_LSB]) == 4'h0) |-> target_delay_auto)
    else $error("code zero did not select automatic delay");

  chk_seq_one_clears: assert property (
    (seq_gd_top_write and writedata[SEQ_OFF_BIT]) |=> !regulator_sequencing_off)
    else $error("writing one did not clear sequencing off");

  chk_seq_never_sets: assert property (
    !$rose(regulator_sequencing_off))
    else $error("sequencing off was set outside reset");

  chk_current_limit_write: assert property (
    seq_gd_mid_write |=> regulator_current_limit_sel == $past(writedata[CUR_LIM_BIT]))
    else $error("current limit select did not follow the write");

  chk_voltage_sel_write: assert property (
    seq_gd_mid_write |=> regulator_voltage_sel == $past(writedata[VSEL_MSB:VSEL_LSB]))
    else $error("voltage select did not follow the write");

  chk_unmapped_reads_zero: assert property (
    (seq_request_seen and (read && !hit_any)) ##1 seq_answer |->
      (readdata == '0 && response == RESP_DECODE_ERR))
    else $error("unmapped read did not return zero with decode error");

  chk_algo_one_store: assert property (
    (accept_wr && hit_one && byteenable == 4'hf) |=> algorithm_config_one == $past(writedata))
    else $error("first algorithm word did not store a full write");

  chk_algo_two_store: assert property (
    (accept_wr && hit_two && byteenable == 4'hf) |=> algorithm_config_two == $past(writedata))
    else $error("second algorithm word did not store a full write");

  chk_gd_readback: assert property (
    (seq_request_seen and (read && hit_gd)) ##1 seq_answer |->
      (readdata == $past(gd_two_q) && response == RESP_OKAY))
    else $error("gate driver word read back wrong");

  chk_parity_plain: assert property (
    seq_gd_top_write |=> gd_two_q[PARITY_BIT] == $past(writedata[PARITY_BIT]))
    else $error("parity bit did not store as plain data");

  chk_bus_one_wait: assert property (
    seq_request_seen |=> seq_answer ##1 waitrequest)
    else $error("request not answered after exactly one wait cycle");

  // Reset values at the first edge after a release; no request can be accepted yet
  chk_reset_words: assert property (
    $past(reset) |->
      (gd_two_q == GD_TWO_RESET && algo_one_q == ALGO_RESET && algo_two_q == ALGO_RESET))
    else $error("register words did not come out of reset at their reset values");

  chk_reset_fields: assert property (
    $past(reset) |->
      (!delay_comp_en && regulator_sequencing_off &&
       regulator_current_limit_sel == CUR_LIM_600MA && regulator_voltage_sel == VSEL_5V0))
    else $error("gate driver fields did not come out of reset at their reset values");

  // Fields follow only the lanes that carry them
  chk_delay_field_store: assert property (
    seq_gd_top_write |=> gd_two_q[TD_MSB:TD_LSB] == $past(writedata[TD_MSB:TD_LSB]))
    else $error("target delay field did not follow the write");

  chk_seq_zero_keeps: assert property (
    (seq_gd_top_write and !writedata[SEQ_OFF_BIT]) |=> $stable(regulator_sequencing_off))
    else $error("writing zero changed sequencing off");

  chk_top_lane_keeps: assert property (
    (accept_wr && hit_gd && !byteenable[3]) |=> $stable(gd_two_q[31:24]))
    else $error("top byte changed without its lane enabled");

  chk_reserved_plain: assert property (
    seq_gd_mid_write |=> gd_two_q[20:16] == $past(writedata[20:16]))
    else $error("reserved bits did not store as plain data");

  chk_low_lanes_plain: assert property (
    (accept_wr && hit_gd && byteenable[1:0] == 2'h3) |=> gd_two_q[15:0] == $past(writedata[15:0]))
    else $error("low reserved bits did not store as plain data");

  // Words hold between accepted writes, so unmapped writes touch nothing
  chk_gd_holds: assert property (
    !(accept_wr && hit_gd) |=> $stable(gd_two_q))
    else $error("gate driver word changed without an accepted write");

  chk_algo_holds: assert property (
    !(accept_wr && (hit_one || hit_two)) |=> ($stable(algo_one_q) && $stable(algo_two_q)))
    else $error("algorithm word changed without an accepted write");

  // Read answers carry the word as it stood when the request was seen
  chk_algo_one_read: assert property (
    (seq_request_seen and (read && hit_one)) ##1 seq_answer |->
      (readdata == $past(algo_one_q) && response == RESP_OKAY))
    else $error("first algorithm word read back wrong");

  chk_algo_two_read: assert property (
    (seq_request_seen and (read && hit_two)) ##1 seq_answer |->
      (readdata == $past(algo_two_q) && response == RESP_OKAY))
    else $error("second algorithm word read back wrong");

endmodule // dcr_top

// *** bench/test_dcr_top.sv ***
`timescale 1ns/1ps
// Self-checking bench for the driver configuration register bank
module test_dcr_top;
  import dcr_pkg::*;

  // Byte addresses of the mapped words
  localparam logic [9:0] A_ONE = 10'h280;
  localparam logic [9:0] A_TWO = 10'h288;
  localparam logic [9:0] A_GD = 10'h2b8;

  logic core_clk;
  logic reset;
  logic [ADDR_W-1:0] address;
  logic read;
  logic write;
  logic [DATA_W-1:0] writedata;
  logic [BE_W-1:0] byteenable;
  logic [DATA_W-1:0] readdata;
  logic [1:0] response;
  logic waitrequest;
  logic delay_comp_en;
  logic target_delay_auto;
  logic [TD_CYC_W-1:0] target_delay_cycles;
  logic regulator_sequencing_off;
  logic regulator_current_limit_sel;
  logic [1:0] regulator_voltage_sel;
  logic [DATA_W-1:0] algorithm_config_one;
  logic [DATA_W-1:0] algorithm_config_two;
  int n_fail = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [31:0] rd;
  logic [1:0] rs;

  dcr_top u_dut (
    .core_clk(core_clk), .reset(reset), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .response(response), .waitrequest(waitrequest), .delay_comp_en(delay_comp_en),
    .target_delay_auto(target_delay_auto), .target_delay_cycles(target_delay_cycles),
    .regulator_sequencing_off(regulator_sequencing_off),
    .regulator_current_limit_sel(regulator_current_limit_sel),
    .regulator_voltage_sel(regulator_voltage_sel),
    .algorithm_config_one(algorithm_config_one), .algorithm_config_two(algorithm_config_two)
  );

  // 125 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // Verdict and end of run, shared by the main sequence and the timeout
  task automatic results();
    $display("Counts: %0d mismatches in %0d comparisons", n_fail, comparisons);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One Avalon access; holds the request until waitrequest is sampled low at a rising edge
  task automatic bus_op(input bit wr, input logic [9:0] a, input logic [31:0] d,
                        input logic [3:0] be, output logic [31:0] q, output logic [1:0] r);
    @(posedge core_clk);
    address <= a;
    writedata <= d;
    byteenable <= be;
    read <= !wr;
    write <= wr;
    // Values read just after an edge are those the slave saw there; the hang guard ends a stall
    do begin
      @(posedge core_clk);
    end while (waitrequest !== 1'b0);
    q = readdata;
    r = response;
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic wr32(input logic [9:0] a, input logic [31:0] d, input logic [3:0] be);
    logic [31:0] q;
    logic [1:0] r;
    bus_op(1'b1, a, d, be, q, r);
    repeat (3) @(negedge core_clk);
  endtask

  task automatic rd_check(input logic [9:0] a, input logic [31:0] exp, input logic [1:0] er);
    bus_op(1'b0, a, 32'h00000000, 4'hf, rd, rs);
    check(rd, exp);
    check({30'h0, rs}, {30'h0, er});
  endtask

  // Field outputs against one expected gate driver word
  task automatic port_check(input logic [31:0] w);
    logic [3:0] c;
    c = w[29:26];
    check({31'h0, delay_comp_en}, {31'h0, w[30]});
    check({31'h0, target_delay_auto}, {31'h0, c == 4'h0});
    check(32'(target_delay_cycles), c == 4'h0 ? 32'h0 : (32'(c) + 1) * 200 / 8);
    check({31'h0, regulator_sequencing_off}, {31'h0, w[24]});
    check({31'h0, regulator_current_limit_sel}, {31'h0, w[23]});
    check({30'h0, regulator_voltage_sel}, {30'h0, w[22:21]});
  endtask

  task automatic reset_check();
    rd_check(A_ONE, 32'h00000000, 2'h0);
    rd_check(A_TWO, 32'h00000000, 2'h0);
    rd_check(A_GD, 32'h01200000, 2'h0);
    port_check(32'h01200000);
    check(algorithm_config_one | algorithm_config_two, 32'h00000000);
  endtask

  // Hang guard
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_fail++;
      results();
    end
  end

  initial begin
    logic [31:0] w;
    reset = 1'b1;
    address = '0;
    read = 1'b0;
    write = 1'b0;
    writedata = '0;
    byteenable = 4'hf;
    repeat (8) @(posedge core_clk);
    reset <= 1'b0;
    reset_check();
    // Writing zero to the sequencing bit leaves it set; parity and reserved bits store
    wr32(A_GD, 32'hfee5a5a5, 4'hf);
    rd_check(A_GD, 32'hffe5a5a5, 2'h0);
    port_check(32'hffe5a5a5);
    // Writing one clears it; a later zero cannot set it again
    wr32(A_GD, 32'h01000000, 4'hf);
    rd_check(A_GD, 32'h00000000, 2'h0);
    wr32(A_GD, 32'h00000000, 4'hf);
    rd_check(A_GD, 32'h00000000, 2'h0);
    // Every delay code, with limit and voltage codes cycling alongside
    for (int c = 0; c < 16; c++) begin
      w = (32'(c) << 26) | (32'(c & 1) << 23) | (32'(c & 3) << 21);
      wr32(A_GD, w, 4'hf);
      port_check(w);
    end
    // Algorithm words, one with lane enables
    wr32(A_ONE, 32'h12345678, 4'hf);
    wr32(A_TWO, 32'hffffffff, 4'h5);
    rd_check(A_ONE, 32'h12345678, 2'h0);
    rd_check(A_TWO, 32'h00ff00ff, 2'h0);
    check(algorithm_config_one, 32'h12345678);
    check(algorithm_config_two, 32'h00ff00ff);
    // Unmapped and misaligned places refuse; a stray write leaves neighbours alone
    wr32(10'h284, 32'hdeadbeef, 4'hf);
    rd_check(10'h284, 32'h00000000, 2'h3);
    rd_check(10'h281, 32'h00000000, 2'h3);
    rd_check(A_ONE, 32'h12345678, 2'h0);
    rd_check(A_TWO, 32'h00ff00ff, 2'h0);
    // Second reset in mid-run brings every word back
    @(posedge core_clk);
    reset <= 1'b1;
    repeat (3) @(posedge core_clk);
    reset <= 1'b0;
    reset_check();
    // Lane three off: the top byte, sequencing bit included, keeps its reset value
    wr32(A_GD, 32'hffffffff, 4'h7);
    rd_check(A_GD, 32'h01ffffff, 2'h0);
    port_check(32'h01ffffff);
    results();
  end
endmodule // test_dcr_top
